// ---- logic/ssl_regs.sv ----
// Overview of operation
// RULE_01 - Temperature fault sets its status flag
// RULE_02 - Status-two read or report clears temperature flag
// RULE_03 - Oscillator training fault sets bit six
// RULE_04 - Oscillator flag clears only after fault ends
// RULE_05 - Read-only revision register, mode-dependent default
// RULE_06 - Revision write answers valid with zero
// RULE_07 - Read-only eight-bit die temperature register
// RULE_08 - Access only in DSI3 or PSI5 diagnostic
// RULE_09 - Lock register layout, all bits reset zero
// RULE_10 - Locked: only reset code bits writable
// RULE_11 - Init lock stays set until reset
// RULE_12 - Locked: recompute and compare detection code
// RULE_13 - Lock setting forces pressure filter final
// RULE_14 - Lock stops and refuses self-test
// RULE_15 - DSI3 lock forces periodic mode, silences commands
// RULE_16 - PSI5 sets lock leaving phase three
// RULE_17 - Disable bit suppresses supply fault reporting
// RULE_18 - Codes 00, 11, 01 consecutively reset device
// RULE_19 - Master sends reset codes back to back
// RULE_20 - Temperature flag at status-two bit two
// RULE_21 - Other command restarts reset sequence tracking
`timescale 1ns/1ns
`include "ssl_defines.svh"

module ssl_regs import ssl_pkg::*; (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire ssl_cmd_type cmd_i,
    output ssl_rsp_type rsp_o,
    input wire logic psi5_mode_i,
    input wire logic psi5_diag_i,
    input wire logic phase3_exit_i,
    input wire logic temp_fault_i,
    input wire logic osc_fault_i,
    input wire logic [7:0] temp_value_i,
    input wire logic stat_tx_temp_i,
    input wire logic stat_tx_osc_i,
    input wire logic selftest_req_i,
    output logic init_complete_lock_o,
    output logic supply_fault_report_disable_o,
    output logic soft_reset_o,
    output logic p0_final_o,
    output logic selftest_run_o,
    output logic pdcm_force_o,
    output logic edc_mismatch_o,
    output logic temperature_fault_flag_o,
    output logic oscillator_training_fault_o
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] lock_image(input logic lk, input logic sd,
                                              input logic [1:0] rc);
        logic [7:0] v;
        v = `SSL_LOCK_RESET;
        v[`SSL_LOCK_INIT_BIT] = lk;
        v[`SSL_LOCK_SUP_BIT] = sd;
        v[`SSL_LOCK_RST_MSB:`SSL_LOCK_RST_LSB] = rc;
        return v;
    endfunction

    // CRC-8 over the protected part of the lock register
    function automatic logic [7:0] edc_code(input logic [7:0] v);
        logic [7:0] c;
        c = `SSL_EDC_SEED ^ v;
        for (int i = 0; i < 8; i++) begin
            if (c[7]) begin
                c = {c[6:0], 1'b0} ^ `SSL_EDC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction

    ssl_state_type q;
    ssl_state_type n;
    logic mode_ok;
    logic accept;
    logic wr_lock;
    logic rd_stat2;
    logic rd_stat3;
    logic [1:0] code;

    // ****************************************
    // Command gating
    // ****************************************
    assign mode_ok = !psi5_mode_i || psi5_diag_i; // see RULE_08
    assign accept = cmd_i.valid && mode_ok && !(!psi5_mode_i && q.lock); // see RULE_15
    assign wr_lock = accept && cmd_i.write && (cmd_i.addr == `SSL_ADDR_LOCK);
    assign rd_stat2 = accept && !cmd_i.write && (cmd_i.addr == `SSL_ADDR_STAT2);
    assign rd_stat3 = accept && !cmd_i.write && (cmd_i.addr == `SSL_ADDR_STAT3);
    assign code = cmd_i.data[`SSL_LOCK_RST_MSB:`SSL_LOCK_RST_LSB];

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        n = q;
        n.soft_rst = 1'b0;
        n.p0_final = 1'b0;
        n.rsp = '0;

        // Three-stage input synchronisers with agreement filter
        n.tsync = {q.tsync[1:0], temp_fault_i};
        n.osync = {q.osync[1:0], osc_fault_i};
        if (q.tsync[1] == q.tsync[2]) begin
            n.temp_filt = q.tsync[2];
        end
        if (q.osync[1] == q.osync[2]) begin
            n.osc_filt = q.osync[2];
        end

        // Sticky fault flags, set beats clear
        n.temp_flag = q.temp_filt // see RULE_01
                      | (q.temp_flag & ~(rd_stat2 | stat_tx_temp_i)); // see RULE_02
        // Clear only while the fault is absent, since set dominates
        n.osc_flag = q.osc_filt | (q.osc_flag & ~(rd_stat3 | stat_tx_osc_i)); // see RULE_04

        n.temp_val = temp_value_i; // see RULE_07

        // Revision default picked once after reset release
        if (!q.rev_loaded) begin
            n.rev = psi5_mode_i ? `SSL_REV_PSI5_DEFAULT : `SSL_REV_DSI3_DEFAULT; // see RULE_05
            n.rev_loaded = 1'b1;
        end

        // Lock register writes
        if (wr_lock) begin
            n.rst_code = code;
            if (!q.lock) begin // see RULE_10
                n.lock = cmd_i.data[`SSL_LOCK_INIT_BIT]; // see RULE_09
                n.sup_dis = cmd_i.data[`SSL_LOCK_SUP_BIT]; // see RULE_17
            end
        end
        if (psi5_mode_i && phase3_exit_i) begin
            n.lock = 1'b1; // see RULE_16
        end
        if (q.lock) begin
            n.lock = 1'b1; // see RULE_11
        end

        n.p0_final = n.lock && !q.lock; // see RULE_13
        n.selftest = selftest_req_i && !n.lock; // see RULE_14
        n.pdcm = n.lock && !psi5_mode_i; // see RULE_15

        // Detection code snapshot on lock, then continuous compare
        if (n.lock && !q.lock) begin
            n.edc_ref = edc_code(lock_image(n.lock, n.sup_dis, 2'h0)); // see RULE_12
        end else if (q.lock && (edc_code(lock_image(q.lock, q.sup_dis, 2'h0)) != q.edc_ref)) begin
            n.edc_mis = 1'b1; // see RULE_12
        end

        // Software reset sequence
        if (accept) begin
            if (wr_lock) begin
                case (q.seq)
                    SSL_SEQ_IDLE: begin
                        n.seq = (code == `SSL_RST_STEP1) ? SSL_SEQ_GOT1 : SSL_SEQ_IDLE;
                    end
                    SSL_SEQ_GOT1: begin
                        if (code == `SSL_RST_STEP2) begin
                            n.seq = SSL_SEQ_GOT2;
                        end else begin
                            n.seq = (code == `SSL_RST_STEP1) ? SSL_SEQ_GOT1 : SSL_SEQ_IDLE;
                        end
                    end
                    SSL_SEQ_GOT2: begin
                        n.soft_rst = (code == `SSL_RST_STEP3); // see RULE_18
                        n.seq = (code == `SSL_RST_STEP1) ? SSL_SEQ_GOT1 : SSL_SEQ_IDLE;
                    end
                    default: begin
                        n.seq = SSL_SEQ_IDLE;
                    end
                endcase
            end else begin
                n.seq = SSL_SEQ_IDLE; // see RULE_21
            end
        end

        // Response
        if (accept) begin
            n.rsp.valid = 1'b1;
            n.rsp.ok = 1'b1;
            case (cmd_i.addr)
                `SSL_ADDR_STAT2: begin
                    n.rsp.data[`SSL_STAT2_TEMP_BIT] = q.temp_flag; // see RULE_20
                end
                `SSL_ADDR_STAT3: begin
                    n.rsp.data[`SSL_STAT3_OSC_BIT] = q.osc_flag; // see RULE_03
                end
                `SSL_ADDR_REV: begin
                    n.rsp.data = cmd_i.write ? `SSL_RSP_WR_REV : {4'h0, q.rev}; // see RULE_06
                end
                `SSL_ADDR_TEMP: begin
                    n.rsp.data = q.temp_val;
                end
                `SSL_ADDR_LOCK: begin
                    n.rsp.data = lock_image(n.lock, n.sup_dis, n.rst_code);
                end
                default: begin
                    n.rsp.ok = 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign rsp_o = q.rsp;
    assign init_complete_lock_o = q.lock;
    assign supply_fault_report_disable_o = q.sup_dis;
    assign soft_reset_o = q.soft_rst;
    assign p0_final_o = q.p0_final;
    assign selftest_run_o = q.selftest;
    assign pdcm_force_o = q.pdcm;
    assign edc_mismatch_o = q.edc_mis;
    assign temperature_fault_flag_o = q.temp_flag;
    assign oscillator_training_fault_o = q.osc_flag;

    // ****************************************
    // Checks
    // ****************************************
    temp_flag_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_01
        q.temp_filt |=> temperature_fault_flag_o)
        else $error("temperature flag not set by fault");

    temp_flag_clr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_02
        (rd_stat2 && !q.temp_filt) |=> !temperature_fault_flag_o)
        else $error("temperature flag not cleared by read");

    osc_flag_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_04
        (oscillator_training_fault_o && q.osc_filt) |=> oscillator_training_fault_o)
        else $error("oscillator flag cleared while fault present");

    rev_write_zero_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_06
        (accept && cmd_i.write && cmd_i.addr == `SSL_ADDR_REV)
        |=> (rsp_o.valid && rsp_o.ok && rsp_o.data == 8'h00))
        else $error("revision write response not zero");

    mode_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_08
        (psi5_mode_i && !psi5_diag_i) |=> !rsp_o.valid)
        else $error("response outside allowed mode");

    lock_sticky_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_11
        init_complete_lock_o |=> init_complete_lock_o && $stable(supply_fault_report_disable_o))
        else $error("locked bits changed");

    p0_force_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_13
        $rose(init_complete_lock_o) |-> p0_final_o ##1 !p0_final_o)
        else $error("filter force pulse missing");

    selftest_block_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_14
        init_complete_lock_o |-> !selftest_run_o)
        else $error("self-test runs while locked");

    crm_silent_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_15
        (init_complete_lock_o && !psi5_mode_i) |=> (pdcm_force_o && !rsp_o.valid))
        else $error("locked DSI3 still answers commands");

    psi5_autolock_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_16
        (psi5_mode_i && phase3_exit_i) |=> init_complete_lock_o)
        else $error("phase three exit did not lock");

    reset_seq_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_18
        soft_reset_o |-> ($past(q.seq) == SSL_SEQ_GOT2 && $past(wr_lock)
                          && $past(code) == `SSL_RST_STEP3))
        else $error("soft reset without full sequence");

    temp_tx_clr_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_02
        (stat_tx_temp_i && !q.temp_filt) |=> !temperature_fault_flag_o)
        else $error("temperature flag not cleared by status report");

    osc_flag_set_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_03
        q.osc_filt |=> oscillator_training_fault_o)
        else $error("oscillator flag not set by fault");

    temp_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_07
        (accept && !cmd_i.write && cmd_i.addr == `SSL_ADDR_TEMP)
        |=> (rsp_o.data == $past(q.temp_val)))
        else $error("temperature read data wrong");

    lock_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_09
        (wr_lock && !q.lock && !phase3_exit_i)
        |=> (init_complete_lock_o == $past(cmd_i.data[`SSL_LOCK_INIT_BIT])))
        else $error("lock bit not written");

    sup_dis_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_17
        (wr_lock && !q.lock)
        |=> (supply_fault_report_disable_o == $past(cmd_i.data[`SSL_LOCK_SUP_BIT])))
        else $error("supply report disable not written");

    seq_restart_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see RULE_21
        (accept && !wr_lock) |=> (q.seq == SSL_SEQ_IDLE))
        else $error("reset tracking not restarted");

endmodule

// ---- common/ssl_defines.svh ----
`ifndef SSL_DEFINES_SVH
`define SSL_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define SSL_ADDR_STAT2 8'h03
`define SSL_ADDR_STAT3 8'h04
`define SSL_ADDR_REV 8'h05
`define SSL_ADDR_TEMP 8'h0E
`define SSL_ADDR_LOCK 8'h10

// ****************************************
// Field positions
// ****************************************
`define SSL_STAT2_TEMP_BIT 2
`define SSL_STAT3_OSC_BIT 6
`define SSL_LOCK_INIT_BIT 7
`define SSL_LOCK_SUP_BIT 3
`define SSL_LOCK_RST_MSB 1
`define SSL_LOCK_RST_LSB 0

// ****************************************
// Values
// ****************************************
`define SSL_LOCK_RESET 8'h00
// Arbitrary revision codes, not tied to any part
`define SSL_REV_DSI3_DEFAULT 4'hA
`define SSL_REV_PSI5_DEFAULT 4'hB
`define SSL_RST_STEP1 2'h0
`define SSL_RST_STEP2 2'h3
`define SSL_RST_STEP3 2'h1
`define SSL_EDC_POLY 8'h07
`define SSL_EDC_SEED 8'hFF
`define SSL_RSP_WR_REV 8'h00

`endif

// ---- common/ssl_pkg.sv ----
package ssl_pkg;

    // ****************************************
    // Command and response carriers
    // ****************************************
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [7:0] data;
    } ssl_cmd_type;

    typedef struct packed {
        logic valid;
        logic ok;
        logic [7:0] data;
    } ssl_rsp_type;

    // ****************************************
    // Reset sequence tracking
    // ****************************************
    typedef enum logic [1:0] {
        SSL_SEQ_IDLE,
        SSL_SEQ_GOT1,
        SSL_SEQ_GOT2
    } ssl_seq_type;

    typedef struct packed {
        logic [2:0] tsync;
        logic [2:0] osync;
        logic temp_filt;
        logic osc_filt;
        logic temp_flag;
        logic osc_flag;
        logic [7:0] temp_val;
        logic [3:0] rev;
        logic rev_loaded;
        logic lock;
        logic sup_dis;
        logic [1:0] rst_code;
        ssl_seq_type seq;
        logic [7:0] edc_ref;
        logic edc_mis;
        logic soft_rst;
        logic p0_final;
        logic selftest;
        logic pdcm;
        ssl_rsp_type rsp;
    } ssl_state_type;

endpackage

// ---- verification/ssl_master_model.sv ----
`timescale 1ns/1ns
module ssl_master_model import ssl_pkg::*; (
    input wire logic clk_i,
    output ssl_cmd_type cmd_o,
    input wire ssl_rsp_type rsp_i
);
    initial begin
        cmd_o = '0;
    end

    // ****************************************
    // One command, then a bounded wait for its answer
    // ****************************************
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic got, output logic [7:0] q, output logic ok);
        cmd_o <= '{valid: 1'b1, write: wr, addr: a, data: d};
        @(posedge clk_i);
        // Released lines show the inverse, never a stale copy
        cmd_o <= '{valid: 1'b0, write: ~wr, addr: ~a, data: ~d};
        got = 1'b0;
        q = 8'h00;
        ok = 1'b0;
        for (int n = 0; n < 4 && !got; n++) begin
            @(posedge clk_i);
            if (rsp_i.valid === 1'b1) begin
                got = 1'b1;
                q = rsp_i.data;
                ok = rsp_i.ok;
            end
        end
    endtask
endmodule

// ---- verification/sensor_status_lock_registers_bench.sv ----
`timescale 1ns/1ns
`include "ssl_defines.svh"
module sensor_status_lock_registers_bench import ssl_pkg::*;;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    ssl_cmd_type cmd;
    ssl_rsp_type rsp;
    logic pmode = 1'b0, pdiag = 1'b0, ph3 = 1'b0, tf = 1'b0, of = 1'b0;
    logic stt = 1'b0, sto = 1'b0, streq = 1'b0;
    logic [7:0] tv = 8'h5C;
    logic lock, supd, srst, p0f, strun, pdcm, edc, tflag, oflag, g, ok;
    logic [7:0] q;
    int n_errors = 0, compares = 0, n_srst = 0, n_p0 = 0, cyc = 0;
    localparam logic [7:0] L = `SSL_ADDR_LOCK;

    always #5 clk_i = ~clk_i;

    ssl_master_model master_u (.clk_i(clk_i), .cmd_o(cmd), .rsp_i(rsp));

    ssl_regs dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_i(cmd), .rsp_o(rsp),
        .psi5_mode_i(pmode), .psi5_diag_i(pdiag), .phase3_exit_i(ph3),
        .temp_fault_i(tf), .osc_fault_i(of), .temp_value_i(tv),
        .stat_tx_temp_i(stt), .stat_tx_osc_i(sto), .selftest_req_i(streq),
        .init_complete_lock_o(lock), .supply_fault_report_disable_o(supd),
        .soft_reset_o(srst), .p0_final_o(p0f), .selftest_run_o(strun),
        .pdcm_force_o(pdcm), .edc_mismatch_o(edc),
        .temperature_fault_flag_o(tflag), .oscillator_training_fault_o(oflag));

    // ****************************************
    // Pulse counters and hang guard
    // ****************************************
    always @(posedge clk_i) begin
        cyc++;
        if (srst === 1'b1) begin
            n_srst++;
        end
        if (p0f === 1'b1) begin
            n_p0++;
        end
        if (cyc == 2000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic [7:0] exp);
        master_u.xfer(wr, a, d, g, q, ok);
        chk1(g, 1'b1);
        chk8(q, exp);
    endtask

    task automatic nores(input logic [7:0] a);
        master_u.xfer(1'b0, a, 8'h00, g, q, ok);
        chk1(g, 1'b0);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        wt(12);
        sys_rst_i <= 1'b0;
        wt(2);
        acc(0, L, 8'h00, 8'h00);
        acc(0, `SSL_ADDR_REV, 8'h00, {4'h0, `SSL_REV_DSI3_DEFAULT});
        acc(1, `SSL_ADDR_REV, 8'h5A, 8'h00);
        acc(0, `SSL_ADDR_REV, 8'h00, {4'h0, `SSL_REV_DSI3_DEFAULT});
        acc(0, `SSL_ADDR_TEMP, 8'h00, 8'h5C);
        master_u.xfer(1'b0, 8'h7F, 8'h00, g, q, ok);
        chk1(ok, 1'b0);
        tf <= 1'b1;
        wt(6);
        chk1(tflag, 1'b1);
        tf <= 1'b0;
        wt(6);
        acc(0, `SSL_ADDR_STAT2, 8'h00, 8'h04);
        acc(0, `SSL_ADDR_STAT2, 8'h00, 8'h00);
        tf <= 1'b1;
        wt(6);
        tf <= 1'b0;
        wt(6);
        stt <= 1'b1;
        wt(1);
        stt <= 1'b0;
        wt(2);
        chk1(tflag, 1'b0);
        of <= 1'b1;
        wt(6);
        acc(0, `SSL_ADDR_STAT3, 8'h00, 8'h40);
        chk1(oflag, 1'b1);
        of <= 1'b0;
        wt(6);
        chk1(oflag, 1'b1);
        sto <= 1'b1;
        wt(1);
        sto <= 1'b0;
        wt(2);
        chk1(oflag, 1'b0);
        // Wrong order, then an interloper, then the proper sequence
        acc(1, L, 8'h00, 8'h00);
        acc(1, L, 8'h01, 8'h01);
        acc(1, L, 8'h03, 8'h03);
        acc(1, L, 8'h01, 8'h01);
        acc(1, L, 8'h00, 8'h00);
        acc(0, `SSL_ADDR_TEMP, 8'h00, 8'h5C);
        acc(1, L, 8'h03, 8'h03);
        acc(1, L, 8'h01, 8'h01);
        wt(2);
        chk8(8'(n_srst), 8'h00);
        acc(1, L, 8'h00, 8'h00);
        acc(1, L, 8'h03, 8'h03);
        acc(1, L, 8'h01, 8'h01);
        wt(2);
        chk8(8'(n_srst), 8'h01);
        streq <= 1'b1;
        wt(3);
        chk1(strun, 1'b1);
        acc(1, L, 8'h88, 8'h88);
        wt(1);
        chk1(lock, 1'b1);
        chk1(supd, 1'b1);
        chk1(pdcm, 1'b1);
        chk1(strun, 1'b0);
        chk8(8'(n_p0), 8'h01);
        nores(L);
        pmode <= 1'b1;
        pdiag <= 1'b1;
        wt(2);
        acc(1, L, 8'h00, 8'h88);
        acc(1, L, 8'h03, 8'h8B);
        acc(1, L, 8'h01, 8'h89);
        wt(2);
        chk8(8'(n_srst), 8'h02);
        chk1(lock, 1'b1);
        chk1(edc, 1'b0);
        pdiag <= 1'b0;
        wt(1);
        nores(`SSL_ADDR_REV);
        sys_rst_i <= 1'b1;
        pdiag <= 1'b1;
        wt(2);
        chk1(lock, 1'b0);
        sys_rst_i <= 1'b0;
        tv <= 8'hA3;
        wt(2);
        acc(0, `SSL_ADDR_REV, 8'h00, {4'h0, `SSL_REV_PSI5_DEFAULT});
        acc(0, `SSL_ADDR_TEMP, 8'h00, 8'hA3);
        acc(0, L, 8'h00, 8'h00);
        ph3 <= 1'b1;
        wt(1);
        ph3 <= 1'b0;
        wt(2);
        chk1(lock, 1'b1);
        give_verdict();
    end
endmodule
